// *** shared/bbx_pkg.sv ***
// Summary of operation
// - Read-modify-write of the I/O port register takes its source from the pins.
// - Writing the timer count register clears the prescaler when assigned to it.
// - Program-counter change or true test costs a second cycle run as no-op.
// - Add literal adds 8-bit immediate to W, result to W, updates C, digit carry, Z.
// - Bit clear forces chosen bit of file register to zero, flags untouched.
// - Add register sums W and file register, updates C, digit carry, Z, result by destination.
// - Bit set forces chosen bit of file register to one, flags untouched.
// - AND literal ands W with immediate, result to W, updates only Z.
// - Test-skip-if-clear: bit one runs next normally, bit zero turns it into no-op.
// - AND register ands W with file register, updates only Z, result by destination.
// - Destination bit 0 sends result to W, 1 sends it to the file register.
//
// Purpose: shared constants and types of the byte/bit/literal execute unit
// Assumes: 14-bit instruction words, 7-bit file address
// Notes: software registers sit on APB at the byte offsets below
`default_nettype none
package bbx_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int INSN_W = 14;
	// Opcode patterns taken from the top bits of the word
	localparam logic [5:0] OPC_ADD_REG = 6'h07;
	localparam logic [5:0] OPC_AND_REG = 6'h05;
	localparam logic [5:0] OPC_AND_LIT = 6'h39;
	localparam logic [4:0] OPC_ADD_LIT = 5'h1f;
	localparam logic [3:0] OPC_BIT_CLR = 4'h4;
	localparam logic [3:0] OPC_BIT_SET = 4'h5;
	localparam logic [3:0] OPC_BIT_TST = 4'h6;
	// Field positions
	localparam int DEST_POS = 7;
	localparam int BIT_LSB = 7;
	// File addresses with side effects
	localparam logic [6:0] TIMER_ADDR = 7'h01;
	localparam logic [6:0] PCL_ADDR = 7'h02;
	localparam logic [6:0] PORT_ADDR = 7'h05;
	// APB byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] WREG_OFS = 8'h04;
	localparam logic [7:0] FLAGS_OFS = 8'h08;
	localparam logic [7:0] PRESC_OFS = 8'h0c;
	localparam logic [7:0] STATE_OFS = 8'h10;
	// Flag bit positions
	localparam int C_POS = 0;
	localparam int DCARRY_POS = 1;
	localparam int Z_POS = 2;
	localparam int PRESC_W = 8;
	typedef enum logic [2:0] {
		NONE_OP, ADD_LITERAL_OP, AND_LITERAL_OP, ADD_REGISTER_OP,
		AND_REGISTER_OP, BIT_CLEAR_OP, BIT_SET_OP, TEST_SKIP_IF_CLEAR_OP
	} bbx_op_t;
	typedef enum logic {EXEC_ST, NOP_ST} bbx_state_t;
endpackage
`default_nettype wire

// *** hw/bbx_file_ram.sv ***
// Purpose: general file register storage
// Assumes: read is combinational so the next instruction sees fresh data
// Notes: no reset on contents, like ordinary data memory
`default_nettype none
module bbx_file_ram #(
	parameter int DEPTH = 128,
	parameter int WIDTH = 8,
	parameter int AW = 7
) (
	input wire logic sys_clk,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Write at the edge that closes the instruction cycle
	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	assign rdData = mem[rdAddr];
endmodule
`default_nettype wire

// *** hw/bbx_alu.sv ***
// Purpose: combinational arithmetic and bit logic of the execute unit
// Assumes: operands already selected by the caller
// Notes: flags are computed for every op; caller decides which to keep
`default_nettype none
module bbx_alu
	import bbx_pkg::*;
(
	input wire bbx_pkg::bbx_op_t op,
	input wire logic [bbx_pkg::DATA_W-1:0] wVal,
	input wire logic [bbx_pkg::DATA_W-1:0] srcVal,
	input wire logic [bbx_pkg::DATA_W-1:0] literal,
	input wire logic [2:0] bitSel,
	output logic [bbx_pkg::DATA_W-1:0] result,
	output logic carry,
	output logic digitCarry,
	output logic zero,
	output logic testTrue
);
	logic [DATA_W:0] sum;
	logic [4:0] lowSum;
	logic [DATA_W-1:0] addend;
	logic [DATA_W-1:0] mask;

	// Literal ops use the immediate, register ops the file value
	always_comb begin
		addend = (op == ADD_LITERAL_OP || op == AND_LITERAL_OP) ? literal : srcVal;
		mask = 8'h01 << bitSel;
		sum = {1'b0, wVal} + {1'b0, addend};
		lowSum = {1'b0, wVal[3:0]} + {1'b0, addend[3:0]};
		case (op)
			ADD_LITERAL_OP, ADD_REGISTER_OP: result = sum[DATA_W-1:0];
			AND_LITERAL_OP, AND_REGISTER_OP: result = wVal & addend;
			BIT_CLEAR_OP: result = srcVal & ~mask;
			BIT_SET_OP: result = srcVal | mask;
			default: result = srcVal;
		endcase
		carry = sum[DATA_W];
		digitCarry = lowSum[4];
		zero = (result == 8'h00);
		testTrue = ~srcVal[bitSel];
	end
endmodule
`default_nettype wire

// *** hw/bbx_exec_unit.sv ***
// Purpose: execute stage for add/AND literal and register ops and bit ops
// Assumes: instrWord valid with instrValid; pins synchronous to sys_clk
// Notes: APB slave with zero wait states; unmapped offsets answer pslverr
//   read data is sampled in the setup cycle, so a same-cycle instruction is not seen
//   instruction writes to W and flags win over a same-edge bus write
//   the timer count itself is plain file storage; only its prescaler is modelled
`default_nettype none
module bbx_exec_unit
	import bbx_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic instrValid,
	input wire logic [bbx_pkg::INSN_W-1:0] instrWord,
	input wire logic [bbx_pkg::DATA_W-1:0] portPins,
	output logic [bbx_pkg::DATA_W-1:0] portLatch,
	output logic nopCycle,
	output logic pcWritten
);
	// Decoded fields and datapath nets
	bbx_op_t op;
	bbx_state_t state_reg;
	logic [ADDR_W-1:0] fAddr;
	logic dest;
	logic [2:0] bitSel;
	logic [DATA_W-1:0] literal;
	logic [DATA_W-1:0] ramData;
	logic [DATA_W-1:0] srcVal;
	logic [DATA_W-1:0] aluResult;
	logic aluC;
	logic aluDcarry;
	logic aluZ;
	logic testTrue;
	logic exec;
	logic writesFile;
	logic writesW;
	logic twoCycle;
	logic timerHit;
	// Architectural state and bus side registers
	logic [DATA_W-1:0] w_reg;
	logic carry_reg;
	logic dcarry_reg;
	logic zero_reg;
	logic prescAssign_reg;
	logic [PRESC_W-1:0] presc_reg;
	logic [DATA_W-1:0] portLatch_reg;
	logic nop_reg;
	logic pcw_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic apbWr;

	// Opcode decode; everything outside this subset executes as a no-op
	always_comb begin
		fAddr = instrWord[ADDR_W-1:0];
		dest = instrWord[DEST_POS];
		bitSel = instrWord[BIT_LSB+2:BIT_LSB];
		literal = instrWord[DATA_W-1:0];
		if (instrWord[INSN_W-1 -: $bits(OPC_ADD_LIT)] == OPC_ADD_LIT) begin
			op = ADD_LITERAL_OP;
		end else if (instrWord[INSN_W-1 -: $bits(OPC_AND_LIT)] == OPC_AND_LIT) begin
			op = AND_LITERAL_OP;
		end else if (instrWord[INSN_W-1 -: $bits(OPC_ADD_REG)] == OPC_ADD_REG) begin
			op = ADD_REGISTER_OP;
		end else if (instrWord[INSN_W-1 -: $bits(OPC_AND_REG)] == OPC_AND_REG) begin
			op = AND_REGISTER_OP;
		end else if (instrWord[INSN_W-1 -: $bits(OPC_BIT_CLR)] == OPC_BIT_CLR) begin
			op = BIT_CLEAR_OP;
		end else if (instrWord[INSN_W-1 -: $bits(OPC_BIT_SET)] == OPC_BIT_SET) begin
			op = BIT_SET_OP;
		end else if (instrWord[INSN_W-1 -: $bits(OPC_BIT_TST)] == OPC_BIT_TST) begin
			op = TEST_SKIP_IF_CLEAR_OP;
		end else begin
			op = NONE_OP;
		end
	end

	// Port register reads the pins, not the latch, so inputs driven low read low
	assign srcVal = (fAddr == PORT_ADDR) ? portPins : ramData;

	bbx_file_ram #(.DEPTH(1 << ADDR_W), .WIDTH(DATA_W), .AW(ADDR_W)) fileRam (
		.sys_clk(sys_clk),
		.wrEn(writesFile),
		.wrAddr(fAddr),
		.wrData(aluResult),
		.rdAddr(fAddr),
		.rdData(ramData)
	);

	bbx_alu alu (
		.op(op),
		.wVal(w_reg),
		.srcVal(srcVal),
		.literal(literal),
		.bitSel(bitSel),
		.result(aluResult),
		.carry(aluC),
		.digitCarry(aluDcarry),
		.zero(aluZ),
		.testTrue(testTrue)
	);

	// The second cycle of a two-cycle op swallows whatever is offered
	assign exec = instrValid && (state_reg == EXEC_ST);
	assign writesFile = exec && ((dest && (op == ADD_REGISTER_OP || op == AND_REGISTER_OP))
		|| op == BIT_CLEAR_OP || op == BIT_SET_OP);
	assign writesW = exec && (op == ADD_LITERAL_OP || op == AND_LITERAL_OP
		|| (!dest && (op == ADD_REGISTER_OP || op == AND_REGISTER_OP)));
	assign twoCycle = exec && ((op == TEST_SKIP_IF_CLEAR_OP && testTrue)
		|| (writesFile && fAddr == PCL_ADDR));
	assign timerHit = writesFile && fAddr == TIMER_ADDR;
	assign apbWr = psel && penable && pready_reg && pwrite;

	// Cycle sequencing: one no-op cycle after a taken skip or PC write
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_reg <= EXEC_ST;
		end else if (twoCycle) begin
			state_reg <= NOP_ST;
		end else begin
			state_reg <= EXEC_ST;
		end
	end

	// Working register; the instruction wins over a same-cycle APB write
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			w_reg <= 8'h00;
		end else if (writesW) begin
			w_reg <= aluResult;
		end else if (apbWr && paddr == WREG_OFS) begin
			w_reg <= pwdata[DATA_W-1:0];
		end
	end

	// Flags: adds touch all three; ANDs only Z; bit ops none
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			carry_reg <= 1'b0;
			dcarry_reg <= 1'b0;
			zero_reg <= 1'b0;
		end else if (exec && (op == ADD_LITERAL_OP || op == ADD_REGISTER_OP)) begin
			carry_reg <= aluC;
			dcarry_reg <= aluDcarry;
			zero_reg <= aluZ;
		end else if (exec && (op == AND_LITERAL_OP || op == AND_REGISTER_OP)) begin
			zero_reg <= aluZ;
		end else if (apbWr && paddr == FLAGS_OFS) begin
			carry_reg <= pwdata[C_POS];
			dcarry_reg <= pwdata[DCARRY_POS];
			zero_reg <= pwdata[Z_POS];
		end
	end

	// Port output latch mirrors writes to the port address
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			portLatch_reg <= 8'h00;
		end else if (writesFile && fAddr == PORT_ADDR) begin
			portLatch_reg <= aluResult;
		end
	end

	// Prescaler free-runs while assigned; timer writes restart it
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			presc_reg <= '0;
		end else if (timerHit && prescAssign_reg) begin
			presc_reg <= '0;
		end else if (prescAssign_reg) begin
			presc_reg <= presc_reg + 1'b1;
		end
	end

	// Prescaler assignment is software's choice
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prescAssign_reg <= 1'b0;
		end else if (apbWr && paddr == CTRL_OFS) begin
			prescAssign_reg <= pwdata[0];
		end
	end

	// Status pulses toward the fetch side
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			nop_reg <= 1'b0;
			pcw_reg <= 1'b0;
		end else begin
			nop_reg <= twoCycle;
			pcw_reg <= writesFile && fAddr == PCL_ADDR;
		end
	end

	// APB: answer in the first access cycle; read data sampled at setup
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else begin
			pready_reg <= psel && !penable;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
			if (psel && !penable) begin
				if (paddr == CTRL_OFS) begin
					prdata_reg <= {31'h0, prescAssign_reg};
				end else if (paddr == WREG_OFS) begin
					prdata_reg <= {24'h0, w_reg};
				end else if (paddr == FLAGS_OFS) begin
					prdata_reg <= {29'h0, zero_reg, dcarry_reg, carry_reg};
				end else if (paddr == PRESC_OFS) begin
					prdata_reg <= {24'h0, presc_reg};
				end else if (paddr == STATE_OFS) begin
					prdata_reg <= {31'h0, state_reg == NOP_ST};
				end else begin
					pslverr_reg <= 1'b1;
				end
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign portLatch = portLatch_reg;
	assign nopCycle = nop_reg;
	assign pcWritten = pcw_reg;

	// Checks on the execute behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	two_cycle_a: assert property (twoCycle |=> nopCycle && !exec ##1 !nopCycle)
		else $error("two-cycle op did not take exactly one no-op cycle");
	skip_clear_a: assert property (exec && op == TEST_SKIP_IF_CLEAR_OP && !testTrue
		|=> !nopCycle) else $error("skip taken on a set bit");
	add_lit_a: assert property (exec && op == ADD_LITERAL_OP |=>
		{carry_reg, w_reg} == {1'b0, $past(w_reg)} + {1'b0, $past(literal)}
		&& dcarry_reg == $past(aluDcarry))
		else $error("add literal result or carry wrong");
	and_lit_a: assert property (exec && op == AND_LITERAL_OP |=>
		$stable(carry_reg) && $stable(dcarry_reg) && zero_reg == (w_reg == 8'h00))
		else $error("AND literal touched a carry or set zero wrong");
	bit_clr_a: assert property (exec && op == BIT_CLEAR_OP |-> writesFile
		&& !aluResult[bitSel] ##1 $stable(zero_reg)) else $error("bit clear wrong");
	bit_set_a: assert property (exec && op == BIT_SET_OP |-> writesFile
		&& aluResult[bitSel] ##1 $stable(carry_reg)) else $error("bit set wrong");
	presc_clear_a: assert property (timerHit && prescAssign_reg |=> presc_reg == 8'h00)
		else $error("prescaler not cleared by timer write");
	add_dest_a: assert property (exec && op == ADD_REGISTER_OP && !dest
		|-> !writesFile ##1 w_reg == $past(aluResult)) else $error("add register to W wrong");
	and_dest_a: assert property (exec && op == AND_REGISTER_OP && dest |-> writesFile
		&& !writesW && aluResult == (w_reg & srcVal)) else $error("AND register to file wrong");
	port_src_a: assert property (writesFile && fAddr == PORT_ADDR && op == ADD_REGISTER_OP
		|=> portLatch == $past(w_reg) + $past(portPins)) else $error("port source not pins");
	zero_flag_a: assert property (exec && op == ADD_REGISTER_OP |=> zero_reg == $past(aluZ))
		else $error("zero flag wrong after add");

	// Checks on bus answer, sequencing, discard, port latch hold and prescaler
	pc_write_a: assert property (writesFile && fAddr == PCL_ADDR
		|=> pcWritten && nopCycle) else $error("PC write did not cost a no-op cycle");
	skip_taken_a: assert property (exec && op == TEST_SKIP_IF_CLEAR_OP && testTrue
		|=> nopCycle && state_reg == NOP_ST) else $error("skip not taken on a clear bit");
	nop_quiet_a: assert property (state_reg == NOP_ST && !(apbWr && paddr == WREG_OFS)
		|=> $stable(w_reg)) else $error("discarded instruction changed W");
	port_hold_a: assert property (!(writesFile && fAddr == PORT_ADDR)
		|=> $stable(portLatch)) else $error("port latch changed without a port write");
	timer_keep_a: assert property (!prescAssign_reg |=> $stable(presc_reg))
		else $error("prescaler moved while not assigned");
	presc_count_a: assert property (prescAssign_reg && !timerHit
		|=> presc_reg == $past(presc_reg) + 8'h01) else $error("prescaler did not count");
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("bus answer not in the first access cycle");
	apb_map_a: assert property (psel && !penable && paddr == WREG_OFS |=> !pslverr)
		else $error("mapped offset answered with an error");

	// Checks on full result words, flag values and add-to-file destination
	and_carry_a: assert property (exec && op == AND_REGISTER_OP
		|=> $stable(carry_reg) && $stable(dcarry_reg))
		else $error("AND register touched a carry");
	add_sum_a: assert property (exec && op == ADD_REGISTER_OP
		|-> {aluC, aluResult} == {1'b0, w_reg} + {1'b0, srcVal})
		else $error("register sum wrong");
	bit_set_word_a: assert property (exec && op == BIT_SET_OP
		|-> aluResult == (srcVal | (8'h01 << bitSel)))
		else $error("bit set disturbed other bits");
	bit_clr_word_a: assert property (exec && op == BIT_CLEAR_OP
		|-> aluResult == (srcVal & ~(8'h01 << bitSel)))
		else $error("bit clear disturbed other bits");
	and_lit_word_a: assert property (exec && op == AND_LITERAL_OP
		|=> w_reg == ($past(w_reg) & $past(literal)))
		else $error("AND literal result wrong");
	dcarry_add_a: assert property (exec && op == ADD_LITERAL_OP
		|=> dcarry_reg == ($past(w_reg[3:0]) + $past(literal[3:0]) > 5'd15))
		else $error("digit carry wrong after add literal");
	and_zero_a: assert property (exec && op == AND_REGISTER_OP
		|=> zero_reg == ($past(w_reg & srcVal) == 8'h00))
		else $error("AND register zero flag wrong");
	file_dest_a: assert property (exec && op == ADD_REGISTER_OP && dest
		|-> writesFile && !writesW) else $error("add register to file wrong");
endmodule
`default_nettype wire

// *** tb/bbx_exec_unit_tb.sv ***
// Purpose: self-checking bench of the execute unit
// Assumes: zero-wait APB slave, instructions one per cycle
// Notes: file contents are read back as W after an add with d=0
`default_nettype none
module bbx_exec_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import bbx_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, instrValid = 1'b0;
	logic [7:0] paddr = 8'h00, portPins = 8'h00, portLatch;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [13:0] instrWord = 14'h0000;
	logic pready, pslverr, nopCycle, pcWritten, nopSeen, pcSeen;
	logic [31:0] seed = 32'h87cc;
	int fails = 0;
	int comparisons = 0;

	bbx_exec_unit i_bbx_exec_unit (.sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instrValid(instrValid), .instrWord(instrWord), .portPins(portPins),
		.portLatch(portLatch), .nopCycle(nopCycle), .pcWritten(pcWritten));

	// Free-running 40 MHz clock
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Sum with flags packed as {zero, digit carry, carry, sum}
	function automatic logic [10:0] addExp(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		logic [4:0] h;
		s = a + b;
		h = a[3:0] + b[3:0];
		return {s[7:0] == 8'h00, h[4], s[8], s[7:0]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task final_report();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// One APB transfer; pready, prdata and pslverr taken at the completing edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				fails++;
				final_report();
			end
			@(posedge sys_clk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask

	// Two instructions back to back; pulses of the first taken at the second's edge
	task automatic run2(input logic [13:0] w1, input logic [13:0] w2);
		@(posedge sys_clk);
		instrValid <= 1'b1;
		instrWord <= w1;
		@(posedge sys_clk);
		instrWord <= w2;
		@(posedge sys_clk);
		nopSeen = nopCycle;
		pcSeen = pcWritten;
		instrValid <= 1'b0;
	endtask

	task automatic getFile(input logic [6:0] f, output logic [7:0] v);
		logic [31:0] q;
		wr(WREG_OFS, 32'h0);
		run2({6'h07, 1'b0, f}, 14'h0000);
		rd(WREG_OFS, q);
		v = q[7:0];
	endtask

	// Clear by AND with zero, then add the value back in
	task automatic setFile(input logic [6:0] f, input logic [7:0] v);
		wr(WREG_OFS, 32'h0);
		run2({6'h05, 1'b1, f}, 14'h0000);
		wr(WREG_OFS, {24'h0, v});
		run2({6'h07, 1'b1, f}, 14'h0000);
	endtask

	// Main sequence
	initial begin
		logic [31:0] q, p;
		logic e;
		logic [7:0] a, b, c, v;
		logic [6:0] f;
		logic [2:0] bt, fl;
		logic [10:0] r;
		int i;
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		for (i = 0; i < 6; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0, q, e);
			chk(q, 32'h0);
			chk({31'h0, e}, 32'(i == 5));
		end
		$display("reset test done");
		// Give the PC low and timer addresses known contents before they are modified
		setFile(PCL_ADDR, 8'h00);
		setFile(TIMER_ADDR, 8'h00);
		// Literal ops with carry corners first
		for (i = 0; i < 24; i++) begin
			a = (i == 0) ? 8'hff : (i == 1) ? 8'h0f : 8'(rnd());
			b = (i < 2) ? 8'h01 : 8'(rnd());
			wr(WREG_OFS, {24'h0, a});
			wr(FLAGS_OFS, rnd() & 32'h7);
			run2({5'h1f, 1'b0, b}, 14'h0000);
			r = addExp(a, b);
			rd(WREG_OFS, q);
			chk(q, {24'h0, r[7:0]});
			rd(FLAGS_OFS, q);
			chk(q, {29'h0, r[10:8]});
			run2({6'h39, a}, 14'h0000);
			rd(WREG_OFS, q);
			chk(q, {24'h0, r[7:0] & a});
			rd(FLAGS_OFS, q);
			chk(q, {29'h0, (r[7:0] & a) == 8'h00, r[9:8]});
		end
		$display("literal test done");
		// Register add and AND, both destinations
		for (i = 0; i < 16; i++) begin
			f = (i == 0) ? 7'h7f : 7'h20 + 7'(rnd() % 96);
			a = 8'(rnd());
			b = 8'(rnd());
			fl = 3'(rnd());
			setFile(f, b);
			wr(WREG_OFS, {24'h0, a});
			wr(FLAGS_OFS, {29'h0, fl});
			run2({i[1] ? 6'h05 : 6'h07, i[0], f}, 14'h0000);
			r = addExp(a, b);
			v = i[1] ? (a & b) : r[7:0];
			rd(FLAGS_OFS, q);
			chk(q, {29'h0, i[1] ? {v == 8'h00, fl[1:0]} : r[10:8]});
			rd(WREG_OFS, q);
			chk(q, {24'h0, i[0] ? a : v});
			getFile(f, c);
			chk({24'h0, c}, {24'h0, i[0] ? v : b});
		end
		$display("register test done");
		// Bit set and clear, then skip test on that bit
		for (i = 0; i < 16; i++) begin
			f = 7'h20 + 7'(rnd() % 96);
			bt = 3'(rnd());
			b = 8'(rnd());
			fl = 3'(rnd());
			setFile(f, b);
			wr(FLAGS_OFS, {29'h0, fl});
			run2({i[0] ? 4'h5 : 4'h4, bt, f}, 14'h0000);
			rd(FLAGS_OFS, q);
			chk(q, {29'h0, fl});
			getFile(f, c);
			chk({24'h0, c}, {24'h0, i[0] ? b | (8'h01 << bt) : b & ~(8'h01 << bt)});
			wr(WREG_OFS, 32'h0);
			run2({4'h6, bt, f}, {5'h1f, 1'b0, 8'h01});
			chk({31'h0, nopSeen}, {31'h0, ~i[0]});
			rd(WREG_OFS, q);
			chk(q, {31'h0, i[0]});
		end
		// Write to program counter low costs a no-op cycle
		run2({6'h07, 1'b1, PCL_ADDR}, 14'h0000);
		chk({30'h0, pcSeen, nopSeen}, 32'h3);
		$display("bit and skip test done");
		// Port update takes the pin levels, not the latch
		for (i = 0; i < 6; i++) begin
			bt = 3'(rnd());
			v = 8'(rnd());
			a = 8'(rnd());
			wr(WREG_OFS, {24'h0, a});
			@(posedge sys_clk);
			portPins <= v;
			run2(i[0] ? {6'h07, 1'b1, PORT_ADDR} : {4'h5, bt, PORT_ADDR}, 14'h0000);
			chk({24'h0, portLatch}, {24'h0, i[0] ? 8'(v + a) : v | (8'h01 << bt)});
		end
		// Prescaler held while unassigned, cleared when assigned
		wr(CTRL_OFS, 32'h1);
		repeat (40) @(posedge sys_clk);
		wr(CTRL_OFS, 32'h0);
		rd(PRESC_OFS, q);
		chk({31'h0, q >= 32'd40}, 32'h1);
		run2({4'h5, 3'h0, TIMER_ADDR}, 14'h0000);
		rd(PRESC_OFS, p);
		chk(p, q);
		wr(CTRL_OFS, 32'h1);
		run2({4'h5, 3'h0, TIMER_ADDR}, 14'h0000);
		rd(PRESC_OFS, q);
		chk({31'h0, q < 32'd8}, 32'h1);
		$display("port and timer test done");
		// Reset in mid-run returns W, flags and prescaler state to zero
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		rd(WREG_OFS, q);
		chk(q, 32'h0);
		rd(FLAGS_OFS, q);
		chk(q, 32'h0);
		rd(CTRL_OFS, q);
		chk(q, 32'h0);
		rd(PRESC_OFS, q);
		chk(q, 32'h0);
		$display("mid-run reset test done");
		final_report();
	end
endmodule
`default_nettype wire
